// >>> design/csf_flags.sv
// csf_flags.sv: event and line status bank of a memory-card host,
// with an ahb-lite slave, card clock gating and dat3 edge detect.
// assumes: event strobes and live conditions arrive on hclk;
// card pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "csf_regs.svh"

// Functional notes
// - a flag rising 0 to 1 with its mask bit set raises the interrupt.
// - reading event status, by cpu or emulation, clears the flags read.
// - bit 12 sets when the last byte of the programmed length is done.
// - bit 11 sets on an enabled dat3 edge; cleared by a read.
// - bit 10 sets on new rx word; clears on reset, data_flags_clear command, rx read.
// - bit 9 sets on data reset, data_flags_clear command or tx write; clears when sent out... see code.
// - bits 7, 6, 5 set on response, read and write crc errors.
// - bit 4 sets when the response wait expires.
// - bit 3 sets when the read data wait expires.
// - bit 2 sets when a command is sent or its response arrives.
// - bit 1 sets on busy release or when expected busy never shows.
// - bit 0 sets only after transfer complete, after crc and programming.
// - command during transfer pauses data path only if busy is expected.
// - line status is read only and raises no interrupt.
// - line status bit 4 shows the present dat3 pin level.
// - line status bit 3 is high while rx holding register is full.
// - line status bit 2 high when tx holding and shift both empty.
// - bit 1 resets to 1, high while card clock is held low.
// - line status bit 0 is high while the card signals busy.
// - card clock off holds the card clock output low.
// - data path reset high holds data logic disabled and in reset.
module csf_flags (
    input  wire logic              hclk,            // function clock
    input  wire logic              hresetn,         // async reset, low
    input  wire logic              hsel,            // slave select
    input  wire logic [7:0]        haddr,           // byte address
    input  wire logic [1:0]        htrans,          // transfer type
    input  wire logic              hwrite,          // write when high
    input  wire logic [2:0]        hsize,           // transfer size
    input  wire logic              hready,          // bus ready in
    input  wire logic [31:0]       hwdata,          // write data
    output logic      [31:0]       hrdata,          // read data
    output logic                   hreadyout,       // slave ready
    output logic                   hresp,           // always okay
    input  wire logic              emu_evt_read,    // emulation read strobe
    input  wire csf_pkg::csf_evt_type evt,          // event strobes
    input  wire csf_pkg::csf_line_type line,        // live conditions
    input  wire logic              d3_pin,          // card data line 3
    input  wire logic              busy_pin,        // card busy on dat0
    output logic                   irq,             // interrupt pulse
    output logic                   card_clk,        // card clock pin
    output logic                   data_path_reset, // data logic reset
    output logic                   data_pause       // data path paused
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [15:0] event_ff,  nxt_event;
    logic [15:0] line_ff,   nxt_line;
    logic [15:0] mask_ff,   nxt_mask;
    logic [31:0] ctl_ff,    nxt_ctl;
    logic [31:0] rdata_ff,  nxt_rdata;
    logic        wr_pend_ff, nxt_wr_pend;
    logic [7:0]  wr_addr_ff, nxt_wr_addr;
    logic        irq_ff,    nxt_irq;
    logic        clk_ff,    nxt_clk;
    logic [7:0]  div_ff,    nxt_div;
    logic        halt_ff,   nxt_halt;
    logic        d3_prev_ff, nxt_d3_prev;
    logic        xfer_seen_ff, nxt_xfer_seen;
    logic        pause_ff,  nxt_pause;
    logic        dpr_ff,    nxt_dpr;
    logic        hresetn_q_ff;
    logic [1:0]  pins_sync;
    logic        rd_take;
    logic        wr_take;
    logic [15:0] set_bits;
    logic [15:0] clr_bits;
    logic        d3_level;
    logic        busy_level;

    // --------------------------------------------------------------
    // pin synchroniser
    // --------------------------------------------------------------
    csf_sync2 #(.W(2)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d_async ({d3_pin, busy_pin}),
        .q_sync  (pins_sync)
    );

    assign d3_level   = pins_sync[1];
    assign busy_level = pins_sync[0];

    // address phase taken when selected, nonseq or seq, and ready
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_take = hsel && hready && htrans[1] && hwrite;

    // --------------------------------------------------------------
    // functions
    // --------------------------------------------------------------
    // dat3 edge enabled by select: bit0 rising, bit1 falling
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic       prev,
                                      input logic       now);
        edge_hit = (sel[0] && !prev && now) || (sel[1] && prev && !now);
    endfunction

    // write data merged into a register under its writable mask
    function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [31:0] wm);
        wr_merge = (old & ~wm) | (wd & wm);
    endfunction

    // --------------------------------------------------------------
    // control and mask registers, written in the data phase
    // --------------------------------------------------------------
    always_comb begin
        nxt_wr_pend = wr_take;
        nxt_wr_addr = wr_take ? haddr : wr_addr_ff;
        nxt_mask    = mask_ff;
        nxt_ctl     = ctl_ff;
        if (wr_pend_ff && wr_addr_ff == `CSF_OFF_EVENT_MASK) begin
            nxt_mask = hwdata[15:0] & `CSF_EV_USED_MASK;
        end else if (wr_pend_ff && wr_addr_ff == `CSF_OFF_CONTROL) begin
            nxt_ctl = wr_merge(ctl_ff, hwdata, `CSF_CTL_WMASK);
        end
        // writes to event and line status have no effect
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            mask_ff    <= `CSF_RST_MASK;
            ctl_ff     <= `CSF_RST_CONTROL;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            mask_ff    <= nxt_mask;
            ctl_ff     <= nxt_ctl;
        end
    end

    // --------------------------------------------------------------
    // read data, registered at the end of the address phase
    // --------------------------------------------------------------
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (rd_take) begin
            if (haddr == `CSF_OFF_EVENT_STATUS) begin
                nxt_rdata = {16'h0000, event_ff};
            end else if (haddr == `CSF_OFF_LINE_STATUS) begin
                nxt_rdata = {16'h0000, line_ff};
            end else if (haddr == `CSF_OFF_EVENT_MASK) begin
                nxt_rdata = {16'h0000, nxt_mask};      // forwards a pending write
            end else if (haddr == `CSF_OFF_CONTROL) begin
                nxt_rdata = nxt_ctl;
            end else begin
                nxt_rdata = 32'h0000_0000;             // unmapped reads zero
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // zero wait state slave, okay response only
    assign hrdata    = rdata_ff;
    assign hreadyout = hresetn_q_ff;
    assign hresp     = 1'b0 & hresetn_q_ff;

    // ready flop, high in and after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresetn_q_ff <= 1'b1;
        end else begin
            hresetn_q_ff <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // event set and clear terms
    // --------------------------------------------------------------
    always_comb begin
        set_bits = 16'h0000;
        clr_bits = 16'h0000;
        set_bits[`CSF_EV_XFER_COMPLETE] = evt.xfer_last_byte;
        set_bits[`CSF_EV_CARD_DET_EDGE] = edge_hit(ctl_ff[`CSF_CTL_EDGE_HI:`CSF_CTL_EDGE_LO],
                                                   d3_prev_ff, d3_level);
        set_bits[`CSF_EV_RX_WORD_READY] = evt.rx_word_new && !dpr_ff;
        set_bits[`CSF_EV_TX_WORD_READY] = dpr_ff || evt.tx_data_write
                                          || (evt.cmd_issue && evt.cmd_dflags_clr);
        set_bits[`CSF_EV_RESP_CRC_ERR]  = evt.resp_crc_err;
        set_bits[`CSF_EV_RD_CRC_ERR]    = evt.rd_crc_err;
        set_bits[`CSF_EV_WR_CRC_ERR]    = evt.wr_crc_err;
        set_bits[`CSF_EV_RESP_TIMEOUT]  = evt.resp_timeout;
        set_bits[`CSF_EV_RD_TIMEOUT]    = evt.rd_timeout;
        set_bits[`CSF_EV_CMD_RESP_DONE] = evt.cmd_resp_done;
        set_bits[`CSF_EV_BUSY_RELEASE]  = evt.busy_release;
        set_bits[`CSF_EV_DATA_PHASE_DONE] = evt.data_done && xfer_seen_ff;
        // a read of event status clears every flag it returned
        if ((rd_take && haddr == `CSF_OFF_EVENT_STATUS) || emu_evt_read) begin
            clr_bits = `CSF_EV_USED_MASK;
        end
        // functional clears of rx word ready
        if (dpr_ff || evt.rx_data_read || (evt.cmd_issue && evt.cmd_dflags_clr)) begin
            clr_bits[`CSF_EV_RX_WORD_READY] = 1'b1;
        end
        // tx word ready drops when the word was taken for sending
        if (evt.tx_word_sent) begin
            clr_bits[`CSF_EV_TX_WORD_READY] = 1'b1;
        end
    end

    // --------------------------------------------------------------
    // sticky flags: set wins over clear, reserved bits stay zero
    // --------------------------------------------------------------
    always_comb begin
        // a read and a set in one cycle keep the flag
        nxt_event = ((event_ff & ~clr_bits) | set_bits) & `CSF_EV_USED_MASK;
        nxt_irq   = |(set_bits & ~event_ff & mask_ff);
        nxt_d3_prev = d3_level;
        nxt_xfer_seen = xfer_seen_ff;
        if (evt.xfer_last_byte) begin
            nxt_xfer_seen = 1'b1;
        end else if (set_bits[`CSF_EV_DATA_PHASE_DONE] || dpr_ff) begin
            nxt_xfer_seen = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_ff     <= `CSF_RST_EVENT;
            irq_ff       <= 1'b0;
            d3_prev_ff   <= 1'b0;
            xfer_seen_ff <= 1'b0;
        end else begin
            event_ff     <= nxt_event;
            irq_ff       <= nxt_irq;
            d3_prev_ff   <= nxt_d3_prev;
            xfer_seen_ff <= nxt_xfer_seen;
        end
    end

    assign irq = irq_ff;

    // --------------------------------------------------------------
    // data path reset and pause for busy commands
    // --------------------------------------------------------------
    always_comb begin
        nxt_dpr   = ctl_ff[`CSF_CTL_DATA_RST];
        nxt_pause = pause_ff;
        if (dpr_ff) begin
            nxt_pause = 1'b0;
        end else if (evt.cmd_issue && evt.cmd_busy_exp && line.xfer_active) begin
            nxt_pause = 1'b1;
        end else if (evt.busy_release) begin
            nxt_pause = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dpr_ff   <= 1'b0;
            pause_ff <= 1'b0;
        end else begin
            dpr_ff   <= nxt_dpr;
            pause_ff <= nxt_pause;
        end
    end

    assign data_path_reset = dpr_ff;
    assign data_pause      = pause_ff;

    // --------------------------------------------------------------
    // card clock divider: hclk / (2 * (rate + 1)), gated low
    // --------------------------------------------------------------
    always_comb begin
        // halt forces the pin low at once, divider restarts
        nxt_halt = !ctl_ff[`CSF_CTL_CLK_ON] || line.rx_shift_full
                   || (line.tx_shift_empty && line.xfer_active);
        nxt_div  = div_ff;
        nxt_clk  = clk_ff;
        if (nxt_halt) begin
            nxt_div = 8'h00;
            nxt_clk = 1'b0;
        end else if (div_ff >= ctl_ff[`CSF_CTL_RATE_HI:`CSF_CTL_RATE_LO]) begin
            nxt_div = 8'h00;
            nxt_clk = !clk_ff;
        end else begin
            nxt_div = div_ff + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff  <= 8'h00;
            clk_ff  <= 1'b0;
            halt_ff <= 1'b1;
        end else begin
            div_ff  <= nxt_div;
            clk_ff  <= nxt_clk;
            halt_ff <= nxt_halt;
        end
    end

    assign card_clk = clk_ff;

    // --------------------------------------------------------------
    // line status: live image, read only, no interrupt
    // --------------------------------------------------------------
    always_comb begin
        nxt_line = 16'h0000;
        nxt_line[`CSF_LS_QUEUE_FULL]    = line.queue_full;
        nxt_line[`CSF_LS_QUEUE_EMPTY]   = line.queue_empty;
        nxt_line[`CSF_LS_D3_LEVEL]      = d3_level;
        nxt_line[`CSF_LS_RX_HOLD_FULL]  = line.rx_hold_full;
        nxt_line[`CSF_LS_TX_HOLD_EMPTY] = line.tx_hold_empty
                                          && line.tx_shift_empty;
        nxt_line[`CSF_LS_CLK_HALTED]    = halt_ff;
        nxt_line[`CSF_LS_CARD_BUSY]     = busy_level;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_ff <= `CSF_RST_LINE;
        end else begin
            line_ff <= nxt_line;
        end
    end

endmodule

// >>> design/csf_regs.svh
// csf_regs.svh: offsets, field positions and reset values of the
// card host status flag bank.
// assumes: included by bare name from design files of this block.
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CSF_OFF_EVENT_STATUS   8'h00
`define CSF_OFF_LINE_STATUS    8'h04
`define CSF_OFF_EVENT_MASK     8'h08
`define CSF_OFF_CONTROL        8'h0c

// ----------------------------------------------------------------
// event status bit positions
// ----------------------------------------------------------------
`define CSF_EV_DATA_PHASE_DONE 0
`define CSF_EV_BUSY_RELEASE    1
`define CSF_EV_CMD_RESP_DONE   2
`define CSF_EV_RD_TIMEOUT      3
`define CSF_EV_RESP_TIMEOUT    4
`define CSF_EV_WR_CRC_ERR      5
`define CSF_EV_RD_CRC_ERR      6
`define CSF_EV_RESP_CRC_ERR    7
`define CSF_EV_TX_WORD_READY   9
`define CSF_EV_RX_WORD_READY   10
`define CSF_EV_CARD_DET_EDGE   11
`define CSF_EV_XFER_COMPLETE   12
`define CSF_EV_USED_MASK       16'h1eff

// ----------------------------------------------------------------
// line status bit positions
// ----------------------------------------------------------------
`define CSF_LS_CARD_BUSY       0
`define CSF_LS_CLK_HALTED      1
`define CSF_LS_TX_HOLD_EMPTY   2
`define CSF_LS_RX_HOLD_FULL    3
`define CSF_LS_D3_LEVEL        4
`define CSF_LS_QUEUE_EMPTY     5
`define CSF_LS_QUEUE_FULL      6

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CSF_CTL_DATA_RST       0
`define CSF_CTL_EDGE_LO        2
`define CSF_CTL_EDGE_HI        3
`define CSF_CTL_CLK_ON         8
`define CSF_CTL_RATE_LO        16
`define CSF_CTL_RATE_HI        23
`define CSF_CTL_WMASK          32'h00ff010d

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSF_RST_EVENT          16'h0000
`define CSF_RST_MASK           16'h0000
`define CSF_RST_CONTROL        32'h00ff0000
`define CSF_RST_RATE           8'hff
`define CSF_RST_LINE           16'h0002

`endif

// >>> design/csf_pkg.sv
// csf_pkg.sv: types shared by the card host status flag bank.
// assumes: nothing; all users write csf_pkg::name.
package csf_pkg;

    // one-cycle event strobes from the card bus logic, same clock
    typedef struct packed {
        logic xfer_last_byte;   // last byte of programmed length done
        logic rx_word_new;      // new receive word available
        logic tx_word_sent;     // transmit holding word sent out
        logic rx_data_read;     // rx data register was read
        logic tx_data_write;    // tx data register was written
        logic cmd_issue;        // a command was issued
        logic cmd_dflags_clr;   // data_flags_clear bit of that command
        logic cmd_busy_exp;     // busy_expected bit of that command
        logic resp_crc_err;     // response crc error
        logic rd_crc_err;       // read data crc error
        logic wr_crc_err;       // write data crc error
        logic resp_timeout;     // response wait expired
        logic rd_timeout;       // read data wait expired
        logic cmd_resp_done;    // command sent or response received
        logic busy_release;     // busy left or never appeared
        logic data_done;        // crc check and programming finished
    } csf_evt_type;

    // live conditions from the data path, same clock
    typedef struct packed {
        logic queue_full;       // data queue full
        logic queue_empty;      // data queue empty
        logic rx_hold_full;     // rx holding register full
        logic tx_hold_empty;    // tx holding register empty
        logic tx_shift_empty;   // tx shift register empty
        logic rx_shift_full;    // rx shift register full
        logic xfer_active;      // a block transfer is running
    } csf_line_type;

endpackage

// >>> design/csf_sync2.sv
// csf_sync2.sv: two-flop synchroniser for asynchronous pin levels.
// assumes: destination clock hclk, asynchronous active-low reset.
`timescale 1ns/1ps

module csf_sync2 #(
    parameter int W = 2
) (
    input  wire logic         hclk,     // destination clock
    input  wire logic         hresetn,  // async reset, active low
    input  wire logic [W-1:0] d_async,  // level from a pin
    output logic      [W-1:0] q_sync    // level in hclk domain
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    // --------------------------------------------------------------
    // two stages; only the second stage is read outside
    // --------------------------------------------------------------
    always_comb begin
        nxt_meta = d_async;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign q_sync = sync_ff;

endmodule

// >>> sim/csf_card_model.sv
// csf_card_model.sv: card end of the bus, drives dat3 and busy.
// assumes: bench sets the wanted levels; card_clk comes from uut.
`timescale 1ns/1ps

module csf_card_model (
    input  wire logic card_clk, // card clock from host
    input  wire logic d3_lvl,   // wanted dat3 level
    input  wire logic busy_req, // card wants to be busy
    output logic      d3_pin,   // dat3 as seen by host
    output logic      busy_pin  // busy level to host
);
    // dat3 follows the card's pull state
    assign d3_pin = d3_lvl;
    // busy starts only on a card clock edge, ends at once
    initial busy_pin = 1'b0;
    always @(posedge card_clk or negedge busy_req) begin
        busy_pin <= busy_req;
    end
endmodule

// >>> sim/csf_flags_monitor.sv
// csf_flags_monitor.sv: port checker of the status bank.
// assumes: bound into csf_flags; one clock domain.
`timescale 1ns/1ps

module csf_flags_monitor (
    input wire logic                  hclk,            // clock
    input wire logic                  hresetn,         // reset, low
    input wire logic                  hsel,            // select
    input wire logic [7:0]            haddr,           // address
    input wire logic [1:0]            htrans,          // type
    input wire logic                  hwrite,          // write
    input wire logic                  hready,          // ready in
    input wire logic [31:0]           hrdata,          // read data
    input wire logic                  hreadyout,       // ready out
    input wire logic                  hresp,           // response
    input wire csf_pkg::csf_evt_type  evt,             // strobes
    input wire csf_pkg::csf_line_type line,            // live levels
    input wire logic                  d3_pin,          // dat3
    input wire logic                  irq,             // interrupt
    input wire logic                  data_path_reset, // data reset
    input wire logic                  data_pause       // paused
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // taken transfers by kind
    wire logic tk = hsel && hready && htrans[1];
    wire logic rd_ev = tk && !hwrite && haddr == 8'h00;
    wire logic rd_ls = tk && !hwrite && haddr == 8'h04;
    wire logic wr_ctl = tk && hwrite && haddr == 8'h0c;
    // two event reads with no set cause between them
    sequence two_reads;
        (rd_ev && evt == '0 && !data_path_reset) ##1 (evt == '0 && !data_path_reset) ##1 rd_ev;
    endsequence
    AST_READY: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    AST_LS_RO: assert property (rd_ls |=> hrdata[31:7] == '0) else $error("line top bits");
    AST_LS_LIVE: assert property (rd_ls |=>
        hrdata[6:5] == $past({line.queue_full, line.queue_empty}, 2)
        && hrdata[3] == $past(line.rx_hold_full, 2)
        && hrdata[2] == $past(line.tx_hold_empty && line.tx_shift_empty, 2))
        else $error("line levels wrong");
    AST_EV_CLR: assert property (two_reads |=> (hrdata & 32'hffff_f7ff) == '0)
        else $error("flag not cleared by read");
    AST_IRQ_QUIET: assert property ((evt == '0 && $stable(d3_pin) && $stable(data_path_reset))[*6]
        |-> !irq) else $error("irq without event");
    AST_DPR: assert property ($changed(data_path_reset) |-> $past(wr_ctl, 2) || $past(wr_ctl, 3))
        else $error("data reset moved alone");
    AST_PAUSE_SET: assert property ($rose(data_pause)
        |-> $past(evt.cmd_issue && evt.cmd_busy_exp && line.xfer_active))
        else $error("pause without busy command");
    AST_PAUSE_REL: assert property ($fell(data_pause)
        |-> $past(evt.busy_release) || data_path_reset || $past(data_path_reset))
        else $error("pause left early");
    AST_NOPAUSE: assert property (evt.cmd_issue && !evt.cmd_busy_exp && !data_pause
        |=> !data_pause) else $error("pause on plain command");
    AST_UNMAP: assert property (tk && !hwrite && haddr == 8'h10 |=> hrdata == '0)
        else $error("unmapped read not zero");
endmodule

bind csf_flags csf_flags_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .line(line), .d3_pin(d3_pin),
    .irq(irq), .data_path_reset(data_path_reset), .data_pause(data_pause));

// >>> sim/tb_csf_flags.sv
// tb_csf_flags.sv: bus-level self-checking bench of the status bank.
// assumes: package, design, card model and monitor compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: %h, expected %h", $time, a, b); end end

module tb_csf_flags;
    logic                  hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, emu = 1'b0;
    logic                  d3_lvl = 1'b0, busy_req = 1'b0, c;
    logic [7:0]            haddr = 8'h00;
    logic [1:0]            htrans = 2'h0;
    logic [31:0]           hwdata = 32'h0, rd;
    logic [31:0]           hrdata;
    logic                  hreadyout, hresp, irq, card_clk, dpr, pause, d3_pin, busy_pin;
    csf_pkg::csf_evt_type  evt = '0;
    csf_pkg::csf_line_type line = '0;
    int                    error_cnt = 0, n_tests = 0;
    int                    idx[10] = '{15, 14, 11, 7, 6, 5, 4, 3, 2, 1};
    // clock
    always #5 hclk = ~hclk;
    csf_flags uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .emu_evt_read(emu), .evt(evt), .line(line),
        .d3_pin(d3_pin), .busy_pin(busy_pin), .irq(irq), .card_clk(card_clk),
        .data_path_reset(dpr), .data_pause(pause));
    csf_card_model u_card (.card_clk(card_clk), .d3_lvl(d3_lvl), .busy_req(busy_req),
        .d3_pin(d3_pin), .busy_pin(busy_pin));
    // one single ahb-lite transfer, read data kept in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // one-cycle strobe, irq looked at in the cycle after
    task automatic pulse(input csf_pkg::csf_evt_type v, input logic e_irq);
        evt <= v;
        @(posedge hclk);
        evt <= '0;
        @(posedge hclk);
        `CHK(irq, e_irq)
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        error_cnt++;
        test_done;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(8'h04, 32'h2);
        rdchk(8'h08, 32'h0);
        rdchk(8'h10, 32'h0);
        bus(1'b1, 8'h00, 32'h1fff);
        rdchk(8'h00, 32'h0);
        bus(1'b1, 8'h04, 32'h7f);
        rdchk(8'h04, 32'h2);
        $display("reset and access test done");
        pulse(16'h0010, 1'b0);
        rdchk(8'h00, 32'h10);
        pulse(16'h0001, 1'b0);
        rdchk(8'h00, 32'h0);
        bus(1'b1, 8'h08, 32'h1eff);
        rdchk(8'h08, 32'h1eff);
        for (int i = 0; i < 10; i++) begin
            pulse(16'h1 << idx[i], 1'b1);
            repeat (2) @(posedge hclk);
            rdchk(8'h00, 32'h1 << (idx[i] == 15 ? 12 : idx[i] == 14 ? 10 :
                idx[i] == 11 ? 9 : idx[i]));
            rdchk(8'h00, 32'h0);
        end
        pulse(16'h8000, 1'b1);
        pulse(16'h0001, 1'b1);
        rdchk(8'h00, 32'h1001);
        pulse(16'h4000, 1'b1);
        pulse(16'h1000, 1'b0);
        pulse(16'h0008, 1'b1);
        emu <= 1'b1;
        @(posedge hclk);
        emu <= 1'b0;
        @(posedge hclk);
        rdchk(8'h00, 32'h0);
        pulse(16'h4000, 1'b1);
        pulse(16'h0600, 1'b1);
        rdchk(8'h00, 32'h200);
        line <= 7'h01;
        pulse(16'h0500, 1'b0);
        `CHK(pause, 1'b1)
        pulse(16'h0002, 1'b1);
        `CHK(pause, 1'b0)
        pulse(16'h0400, 1'b0);
        rdchk(8'h00, 32'h2);
        $display("event test done");
        bus(1'b1, 8'h0c, 32'h1);
        repeat (2) @(posedge hclk);
        `CHK(dpr, 1'b1)
        rdchk(8'h00, 32'h200);
        pulse(16'h4000, 1'b0);
        rdchk(8'h00, 32'h200);
        bus(1'b1, 8'h0c, 32'h104);
        line <= 7'h5c;
        d3_lvl <= 1'b1;
        busy_req <= 1'b1;
        repeat (12) @(posedge hclk);
        rdchk(8'h04, 32'h5d);
        rdchk(8'h00, 32'ha00);
        @(posedge hclk);
        c = card_clk;
        @(posedge hclk);
        `CHK(card_clk, ~c)
        bus(1'b1, 8'h0c, 32'h0);
        repeat (4) @(posedge hclk);
        `CHK(card_clk, 1'b0)
        rdchk(8'h04, 32'h5f);
        $display("line and clock test done");
        test_done;
    end
endmodule
